/* File: src/hoist_status_defines.vh */
// register addresses, field positions and reset values of the status word bank
// included by the bank only, not by the bench files; definitions only
`ifndef HOIST_STATUS_DEFINES_VH
`define HOIST_STATUS_DEFINES_VH

`define ADDR_BUTTON_WORD_LOW 16'h0f00
`define ADDR_BUTTON_WORD_HIGH 16'h0f01
`define ADDR_STATION_STATE_SEL 16'h0f02
`define ADDR_STATION_ERR_ROLE 16'h0f03

// station status word fields
`define HOIST1_SEL_LSB 0
`define BRIDGE_SEL_LSB 3
`define UNPAIR_ACK_BIT 5
`define HOIST2_SEL_LSB 6
`define STATION_STATE_LSB 8

// error and role word fields
`define ROLE_LSB 0
`define ERROR_CODE_LSB 8

// button word fields
`define BTN_PAIR_LSB 0
`define BTN_FIVE_LSB 8
`define BTN_EIGHT_LSB 13
`define BTN_NINE_BIT 15
`define BTN_TEN_LSB 0

// selector encodings
`define SEL_NONE 2'h0
`define SEL_UNIT_ONE 2'h1
`define SEL_UNIT_TWO 2'h2
`define SEL_BOTH 2'h3

// station state encodings
`define STATE_HALTED 3'h1
`define STATE_RUNNING 3'h2
`define STATE_ESTOP_ENGAGED 3'h4
`define STATE_ESTOP_DISENGAGED 3'h5
`define STATE_INPUT_TEST_FAIL 3'h6
`define STATE_SAFE_HALT_FAIL 3'h7

// station role encodings
`define ROLE_STANDALONE 2'h0
`define ROLE_PRIMARY 2'h1
`define ROLE_SECONDARY 2'h2

// reset values
`define WORD_RESET 16'h0000
`define BUTTONS_RESET 20'h00000
`define FLAG_RESET 1'b0
`define ROLE_BYTE_RESET 8'h00

`endif

/* File: src/button_sync.v */
// two-flop synchroniser for the remote button levels
// assumes the levels arrive asynchronously to clk
`timescale 1ns/1ns
module button_sync (
  input wire clk,
  input wire rstn,
  input wire [19:0] rawButtons,
  output wire [19:0] syncButtons
);
  reg [19:0] stage1_r;
  reg [19:0] stage2_r;

  genvar i;
  generate
    for (i = 0; i < 20; i = i + 1) begin : gSync
      // first stage feeds only the second stage
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stage1_r[i] <= 1'b0;
          stage2_r[i] <= 1'b0;
        end else begin
          stage1_r[i] <= rawButtons[i];
          stage2_r[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

  assign syncButtons = stage2_r;
endmodule // button_sync

/* File: src/hoist_base_status_words.v */
// read-only bank of four 16-bit status words of the crane base station
// assumes a serial slave front end decodes frames into register reads on clk;
// button levels come from pins, all other status from logic on clk
//
// How it works
// RULE_01: button bit reads 1 pressed, 0 released
// RULE_02: first button word bit layout as mapped
// RULE_03: buttons ten to fifteen on bits 0-5
// RULE_04: hoist selector one at bits 0-1
// RULE_05: bridge selector at bits 3-4
// RULE_06: bit 5 shows unpairing acknowledge
// RULE_07: hoist selector two at bits 6-7
// RULE_08: station state field at bits 8-10
// RULE_09: values 6, 7 mark self-test failures
// RULE_10: low byte of fourth word holds role
// RULE_11: high byte of fourth word holds error
// RULE_12: words read-only; writes have no effect
// RULE_13: reserved bits always read zero
`timescale 1ns/1ns
`include "hoist_status_defines.vh"
module hoist_base_status_words (
  input wire clk,
  input wire rstn,
  // register access from the serial slave front end
  input wire [15:0] regAddr,
  input wire rdStb,
  input wire wrStb,
  output reg [15:0] rdData,
  output reg rdValid,
  output reg addrFault,
  output reg wrRefused,
  // remote button levels, high while held
  input wire [3:0] buttonNormal,
  input wire [3:0] buttonSecond,
  input wire [2:0] buttonFiveToSeven,
  input wire [1:0] buttonEight,
  input wire buttonNine,
  input wire [5:0] buttonTenToFifteen,
  // station status from the control logic
  input wire [1:0] hoistOneSel,
  input wire [1:0] bridgeSel,
  input wire [1:0] hoistTwoSel,
  input wire unpairAck,
  input wire [2:0] stationState,
  input wire [1:0] stationRole,
  input wire [7:0] errorCode
);
  // slices of the synchronised button vector, in pack order
  wire [19:0] rawButtons;
  wire [19:0] syncButtons;
  wire [3:0] normalSync;
  wire [3:0] secondSync;
  wire [2:0] fiveToSevenSync;
  wire [1:0] eightSync;
  wire nineSync;
  wire [5:0] tenToFifteenSync;
  wire [7:0] pairBits;
  // assembled words seen by the read mux
  reg [15:0] buttonLow;
  reg [15:0] buttonHigh;
  reg [15:0] stationWord;
  reg [15:0] errRoleWord;
  reg [2:0] stateShown;
  reg [7:0] roleByte;
  // read path and next values of the answer flops
  reg [15:0] readMux;
  reg readHit;
  reg [15:0] rdData_nxt;
  reg rdValid_nxt;
  reg addrFault_nxt;
  reg wrRefused_nxt;
  genvar p;

  // pack order: normal/second pairs, 5-7, 8 (two bits), 9, 10-15
  assign rawButtons = {buttonTenToFifteen, buttonNine, buttonEight, buttonFiveToSeven,
                       buttonSecond, buttonNormal};

  // pins are asynchronous; nothing reads them before the second stage
  button_sync uSync (
    .clk(clk),
    .rstn(rstn),
    .rawButtons(rawButtons),
    .syncButtons(syncButtons)
  );

  assign normalSync = syncButtons[3:0];
  assign secondSync = syncButtons[7:4];
  assign fiveToSevenSync = syncButtons[10:8];
  assign eightSync = syncButtons[12:11];
  assign nineSync = syncButtons[13];
  assign tenToFifteenSync = syncButtons[19:14];

  // buttons one to four interleave normal and second step
  generate
    for (p = 0; p < 4; p = p + 1) begin : gPair
      assign pairBits[2 * p] = normalSync[p]; // [RULE_01] [RULE_02]
      assign pairBits[2 * p + 1] = secondSync[p]; // [RULE_02]
    end
  endgenerate

  // reserved bits 11 and 12 stay at the cleared default
  always @* begin
    buttonLow = `WORD_RESET; // [RULE_13]
    buttonLow[`BTN_PAIR_LSB +: 8] = pairBits; // [RULE_02]
    buttonLow[`BTN_FIVE_LSB +: 3] = fiveToSevenSync; // [RULE_01] [RULE_02]
    buttonLow[`BTN_EIGHT_LSB +: 2] = eightSync; // [RULE_02]
    buttonLow[`BTN_NINE_BIT] = nineSync; // [RULE_02]
  end

  always @* begin
    buttonHigh = `WORD_RESET; // [RULE_13]
    buttonHigh[`BTN_TEN_LSB +: 6] = tenToFifteenSync; // [RULE_01] [RULE_03]
  end

  // unused codes 0 and 3 are passed as given so faults stay visible
  always @* begin
    stateShown = stationState; // [RULE_08] [RULE_09]
  end

  // bit 2 carries no field and reads zero
  always @* begin
    stationWord = `WORD_RESET; // [RULE_13]
    stationWord[`HOIST1_SEL_LSB +: 2] = hoistOneSel; // [RULE_04]
    stationWord[`BRIDGE_SEL_LSB +: 2] = bridgeSel; // [RULE_05]
    stationWord[`UNPAIR_ACK_BIT] = unpairAck; // [RULE_06]
    stationWord[`HOIST2_SEL_LSB +: 2] = hoistTwoSel; // [RULE_07]
    stationWord[`STATION_STATE_LSB +: 3] = stateShown; // [RULE_08] [RULE_09]
  end

  // role is two bits wide; the rest of the low byte reads zero
  always @* begin
    roleByte = `ROLE_BYTE_RESET; // [RULE_13]
    roleByte[1:0] = stationRole; // [RULE_10]
  end

  // error code values are defined elsewhere and passed unchecked
  always @* begin
    errRoleWord = `WORD_RESET;
    errRoleWord[`ROLE_LSB +: 8] = roleByte; // [RULE_10]
    errRoleWord[`ERROR_CODE_LSB +: 8] = errorCode; // [RULE_11]
  end

  // address decode; anything outside the four words is a fault
  always @* begin
    readMux = `WORD_RESET;
    readHit = 1'b1;
    case (regAddr)
      `ADDR_BUTTON_WORD_LOW: begin
        readMux = buttonLow;
      end
      `ADDR_BUTTON_WORD_HIGH: begin
        readMux = buttonHigh;
      end
      `ADDR_STATION_STATE_SEL: begin
        readMux = stationWord;
      end
      `ADDR_STATION_ERR_ROLE: begin
        readMux = errRoleWord;
      end
      default: begin
        readMux = `WORD_RESET; // [RULE_13]
        readHit = 1'b0;
      end
    endcase
  end

  // rdData holds the last answer until the next read is taken
  always @* begin
    rdData_nxt = rdData;
    if (rdStb) begin
      rdData_nxt = readMux; // [RULE_12]
    end
  end

  // limitation: a held rdStb rereads and answers every cycle
  always @* begin
    rdValid_nxt = rdStb;
  end

  always @* begin
    addrFault_nxt = rdStb & ~readHit;
  end

  // a write never reaches any state, only a refusal pulse
  always @* begin
    wrRefused_nxt = wrStb; // [RULE_12]
  end

  // answer flops, one per output so each stays a plain register
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= `WORD_RESET;
    end else begin
      rdData <= rdData_nxt;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdValid <= `FLAG_RESET;
    end else begin
      rdValid <= rdValid_nxt;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addrFault <= `FLAG_RESET;
    end else begin
      addrFault <= addrFault_nxt;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrRefused <= `FLAG_RESET;
    end else begin
      wrRefused <= wrRefused_nxt;
    end
  end
endmodule // hoist_base_status_words

/* File: test/hoist_status_chk_properties.sv */
// port assertions for the status word bank
// bound to the bank from the bench top; one clock
`timescale 1ns/1ns
module hoist_status_chk (
  input wire clk,
  input wire rstn,
  input wire [15:0] regAddr,
  input wire rdStb,
  input wire wrStb,
  input wire [15:0] rdData,
  input wire rdValid,
  input wire addrFault,
  input wire wrRefused,
  input wire [1:0] hoistOneSel,
  input wire [1:0] bridgeSel,
  input wire unpairAck,
  input wire [2:0] stationState
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rdWord2;
    rdStb && regAddr == 16'h0f02;
  endsequence
  a_read_answer: assert property (rdStb |=> rdValid)
    else $error("read not answered");
  a_no_stray: assert property (!rdStb |=> !rdValid && $stable(rdData))
    else $error("stray read answer");
  a_write_refused: assert property (wrStb |=> wrRefused)
    else $error("write not refused");
  a_fault_unmapped: assert property (rdStb && regAddr[15:2] != 14'h03c0 |=> addrFault && rdData == 16'h0)
    else $error("unmapped read");
  a_hoist_sel: assert property (rdWord2 |=> rdData[1:0] == $past(hoistOneSel))
    else $error("hoist selector");
  a_bridge_sel: assert property (rdWord2 |=> rdData[4:3] == $past(bridgeSel))
    else $error("bridge selector");
  a_unpair_ack: assert property (rdWord2 |=> rdData[5] == $past(unpairAck))
    else $error("unpair flag");
  a_state_field: assert property (rdWord2 |=> rdData[15:8] == {5'h0, $past(stationState)})
    else $error("state field");
endmodule // hoist_status_chk

/* File: test/status_master.sv */
// serial master model: one register read or write at a time
// caller enters after any edge; strobe is held until the taking edge
`timescale 1ns/1ns
module status_master (
  input wire clk,
  input wire [15:0] rdData,
  input wire rdValid,
  input wire addrFault,
  input wire wrRefused,
  output reg [15:0] regAddr,
  output reg rdStb,
  output reg wrStb
);
  initial {regAddr, rdStb, wrStb} = 18'h0;
  task xfer(input w, input [15:0] a, output [15:0] d, output f, output v);
    begin
      @(posedge clk);
      regAddr <= a;
      {wrStb, rdStb} <= w ? 2'h2 : 2'h1;
      @(posedge clk);
      {wrStb, rdStb} <= 2'h0;
      regAddr <= ~a; // idle address must not look like the last one
      #1 d = rdData;
      f = w ? wrRefused : addrFault;
      v = rdValid;
    end
  endtask
endmodule // status_master

/* File: test/hoist_base_status_words_tb_top.sv */
// self-checking bench for the status word bank
// master model drives the register side, bench drives all status levels
`timescale 1ns/1ns
module hoist_base_status_words_tb_top;
  reg clk, rstn, b9, ack, f, v;
  reg [3:0] nrm, sec;
  reg [2:0] b57, st;
  reg [1:0] b8, h1, br, h2, role;
  reg [5:0] b10;
  reg [7:0] err;
  reg [15:0] d;
  wire [15:0] addr, rdData;
  wire rs, ws, af, wr, rv;
  integer i, bad_count, checks;
  hoist_base_status_words i_dut (.clk(clk), .rstn(rstn), .regAddr(addr), .rdStb(rs),
    .wrStb(ws), .rdData(rdData), .rdValid(rv), .addrFault(af), .wrRefused(wr),
    .buttonNormal(nrm), .buttonSecond(sec), .buttonFiveToSeven(b57), .buttonEight(b8),
    .buttonNine(b9), .buttonTenToFifteen(b10), .hoistOneSel(h1), .bridgeSel(br),
    .hoistTwoSel(h2), .unpairAck(ack), .stationState(st), .stationRole(role), .errorCode(err));
  status_master m (.clk(clk), .rdData(rdData), .rdValid(rv), .addrFault(af), .wrRefused(wr),
    .regAddr(addr), .rdStb(rs), .wrStb(ws));
  task cmp(input [15:0] g, input [15:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #20000 bad_count = bad_count + 1;
    stop_test;
  end
  initial begin
    {nrm, sec, b57, b8, b9, b10, h1, br, h2, ack, st, role, err} = 40'h0;
    {rstn, bad_count, checks} = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 cmp(rdData, 16'h0000);
    cmp({13'h0, rv, af, wr}, 16'h0000);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk);
      {nrm, sec, b57, b8, b9, b10} <= i ? 20'ha4495 : 20'h5ab6a;
      repeat (2) @(posedge clk); // two synchroniser stages
      m.xfer(1'b0, 16'h0f00, d, f, v);
      cmp(d, i ? 16'h2264 : 16'hc599);
      cmp({14'h0, f, v}, 16'h0001);
      m.xfer(1'b0, 16'h0f01, d, f, v);
      cmp(d, i ? 16'h0015 : 16'h002a);
    end
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk);
      {h1, br, h2, ack, st} <= {i[1:0], ~i[1:0], i[1:0] + 2'h1, i[0], i[2:0]};
      m.xfer(1'b0, 16'h0f02, d, f, v);
      // bit 2 carries no field and must read zero
      cmp(d, {5'h0, i[2:0], i[1:0] + 2'h1, i[0], ~i[1:0], 1'h0, i[1:0]});
    end
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clk);
      {role, err} <= {i[1:0], 8'h3a + i[7:0]};
      m.xfer(1'b0, 16'h0f03, d, f, v);
      cmp(d, {8'h3a + i[7:0], 6'h0, i[1:0]});
      m.xfer(1'b0, i ? 16'h0eff : 16'h0f04, d, f, v);
      cmp(d, 16'h0000);
      cmp({14'h0, f, v}, 16'h0003);
    end
    m.xfer(1'b1, 16'h0f02, d, f, v);
    cmp({14'h0, f, v}, 16'h0002);
    m.xfer(1'b0, 16'h0f02, d, f, v);
    cmp(d, 16'h0723);
    stop_test;
  end
endmodule // hoist_base_status_words_tb_top
bind hoist_base_status_words hoist_status_chk u_chk (.clk(clk), .rstn(rstn),
  .regAddr(regAddr), .rdStb(rdStb), .wrStb(wrStb), .rdData(rdData), .rdValid(rdValid),
  .addrFault(addrFault), .wrRefused(wrRefused), .hoistOneSel(hoistOneSel),
  .bridgeSel(bridgeSel), .unpairAck(unpairAck), .stationState(stationState));
